// [inc/mli_pkg.sv]
// Purpose: constants for the multiply-low and port-input execution block
// Assumes: 100 MHz sys_clk, AHB-Lite register access, 32-bit words
// Notes: byte offsets are word aligned
package mli_pkg;

	// bus register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_MULTIPLICAND = 8'h04;
	localparam logic [7:0] OFS_OPERAND = 8'h08;
	localparam logic [7:0] OFS_ACCUM = 8'h0C;
	localparam logic [7:0] OFS_PRODUCT = 8'h10;
	localparam logic [7:0] OFS_FLAGS = 8'h14;
	localparam logic [7:0] OFS_OVF_COUNT = 8'h18;
	localparam logic [7:0] OFS_REPEAT = 8'h1C;
	localparam logic [7:0] OFS_COMMAND = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h24;
	localparam logic [7:0] OFS_IO_DATA = 8'h28;
	localparam logic [7:0] OFS_IO_PORT = 8'h2C;

	// field positions
	localparam int CTRL_MODE_BIT = 4;
	localparam int FLAG_Z_BIT = 0;
	localparam int FLAG_N_BIT = 1;
	localparam int FLAG_C_BIT = 2;
	localparam int FLAG_V_BIT = 3;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_ILLEGAL_BIT = 1;

	// values after reset
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [3:0] RST_SHIFT = 4'h2;
	localparam logic [15:0] RST_HALF = 16'h0000;

	// opcodes
	localparam logic [15:0] OP_MUL_SUB = 16'h5643;
	localparam logic [15:0] OP_MUL_MIX = 16'h5665;
	localparam logic [7:0] OP_SECOND_HI = 8'h00;
	localparam logic [7:0] OP_PORT_IN = 8'hB4;
	localparam logic [7:0] DEST_ACCUM_LOW = 8'h20;
	localparam logic [7:0] DEST_ACCUM_HIGH = 8'h21;

	// product shift select codes
	localparam logic [3:0] SHF_LEFT4 = 4'h0;
	localparam logic [3:0] SHF_LEFT1 = 4'h1;
	localparam logic [3:0] SHF_NONE = 4'h2;
	localparam logic [3:0] SHF_RIGHT1 = 4'h3;
	localparam logic [3:0] SHF_RIGHT2 = 4'h4;
	localparam logic [3:0] SHF_RIGHT3 = 4'h5;
	localparam logic [3:0] SHF_RIGHT4 = 4'h6;
	localparam logic [3:0] SHF_RIGHT5 = 4'h7;
	localparam logic [3:0] SHF_RIGHT6 = 4'h8;

	// external bus
	localparam int EXT_ADDR_W = 22;
	localparam int CLK_PERIOD_NS = 10;
	localparam int IO_STROBE_NS = 40;
	localparam int IO_STROBE_CYC = (IO_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0] IO_STROBE_LAST = 3'(IO_STROBE_CYC - 1);

	typedef enum logic [2:0] {IO_IDLE, IO_STROBE, IO_SAMPLE, IO_GAP} mli_io_state_t;

endpackage

// [src/mli_exec.sv]
// Purpose: executes multiply-low-and-subtract, mixed-sign multiply and port input
// Assumes: one AHB-Lite slave on the bus, hready equals our hreadyout
// Notes: a command word write starts one instruction; bus writes ignored while busy
// Notes on behaviour
// - subtract-multiply two-word opcode, object mode only
// - subtract old unsigned product first, then overwrite
// - full product, low 38 bits kept
// - left four: product bits 31..4, low zero
// - left one: product bits 31..1 from 30..0
// - no shift copies bits 31..0
// - right shifts take 32 bits from amount
// - zero flag from accumulator after subtract
// - negative flag copies accumulator bit 31 after subtract
// - carry is inverted borrow
// - overflow flag set on overflow, else kept
// - borrow decrements unsigned overflow counter
// - multiplies clear repeat counter, run once
// - mixed multiply signed times unsigned operand
// - port input copies word, opcode plus address
// - port address space is 16 bits
// - io strobe held low during input access
// - port on low address lines, rest zero
// - input word taken from low data lines
// - repeated input runs N+1, address increments
// - accumulator half destination updates negative, zero
//
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
module mli_exec
	import mli_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	output logic [mli_pkg::EXT_ADDR_W-1:0] extAddr,
	input wire logic [15:0] extData,
	output logic ioStrobe_n,
	output logic extRead_n
);
	import mli_pkg::*;

	// bus slave state
	logic dataPhase_r, write_r, addrOk_r, readyOut_r;
	logic [7:0] addr_r;
	logic [31:0] rdData_r;
	// architectural state
	logic [3:0] shiftSel_r;
	logic object_mode_bit_r;
	logic [31:0] multiplicand_r, operand_r, accum_r, product_r, cmd_r;
	logic flagZ_r, flagN_r, flagC_r, flagV_r;
	logic [15:0] ovfCount_r, repeat_r, ioData_r, ioPort_r;
	logic start_r, illegal_r;
	// io engine
	mli_io_state_t ioState_r;
	logic [2:0] strobeCnt_r;
	logic [15:0] sync1_r, sync2_r, sync3_r;
	logic [EXT_ADDR_W-1:0] extAddr_r;
	logic strobe_n_r, read_n_r;
	// next values
	logic [31:0] accum_nxt, product_nxt;
	logic flagZ_nxt, flagN_nxt, flagC_nxt, flagV_nxt;
	logic [15:0] ovfCount_nxt, repeat_nxt;

	// bus decode
	wire addrPhase = hsel && htrans[1] && hready;
	wire busy = start_r || (ioState_r != IO_IDLE);
	wire wrEn = dataPhase_r && write_r && addrOk_r && !busy;
	wire wrCtrl = wrEn && (addr_r == OFS_CTRL);
	wire wrMultiplicand = wrEn && (addr_r == OFS_MULTIPLICAND);
	wire wrOperand = wrEn && (addr_r == OFS_OPERAND);
	wire wrAccum = wrEn && (addr_r == OFS_ACCUM);
	wire wrProduct = wrEn && (addr_r == OFS_PRODUCT);
	wire wrFlags = wrEn && (addr_r == OFS_FLAGS);
	wire wrOvfCount = wrEn && (addr_r == OFS_OVF_COUNT);
	wire wrRepeat = wrEn && (addr_r == OFS_REPEAT);
	wire wrCommand = wrEn && (addr_r == OFS_COMMAND);
	wire [31:0] flagsWord = {28'h000_0000, flagV_r, flagC_r, flagN_r, flagZ_r};
	wire [31:0] statusWord = {30'h0000_0000, illegal_r, busy};
	wire [31:0] ctrlWord = {27'h000_0000, object_mode_bit_r, shiftSel_r};
	wire [31:0] rdMux =
		!addrOk_r ? RST_WORD :
		(addr_r == OFS_CTRL) ? ctrlWord :
		(addr_r == OFS_MULTIPLICAND) ? multiplicand_r :
		(addr_r == OFS_OPERAND) ? operand_r :
		(addr_r == OFS_ACCUM) ? accum_r :
		(addr_r == OFS_PRODUCT) ? product_r :
		(addr_r == OFS_FLAGS) ? flagsWord :
		(addr_r == OFS_OVF_COUNT) ? {16'h0000, ovfCount_r} :
		(addr_r == OFS_REPEAT) ? {16'h0000, repeat_r} :
		(addr_r == OFS_COMMAND) ? cmd_r :
		(addr_r == OFS_STATUS) ? statusWord :
		(addr_r == OFS_IO_DATA) ? {16'h0000, ioData_r} :
		(addr_r == OFS_IO_PORT) ? {16'h0000, ioPort_r} : RST_WORD;

	// instruction decode
	wire [15:0] word1 = cmd_r[31:16];
	wire [15:0] word2 = cmd_r[15:0];
	wire isMulSub = (word1 == OP_MUL_SUB) && (word2[15:8] == OP_SECOND_HI);
	wire isMulMix = (word1 == OP_MUL_MIX) && (word2[15:8] == OP_SECOND_HI);
	wire isPortIn = (word1[15:8] == OP_PORT_IN);
	wire legalOp = object_mode_bit_r && (isMulSub || isMulMix || isPortIn);
	wire execSub = start_r && object_mode_bit_r && isMulSub;
	wire execMix = start_r && object_mode_bit_r && isMulMix;
	wire execMul = execSub || execMix;
	wire ioGo = start_r && object_mode_bit_r && isPortIn;
	wire [7:0] inDest = word1[7:0];

	// multiplier, signed or unsigned operand
	wire signed [32:0] mulA = {multiplicand_r[31], multiplicand_r};
	wire signed [32:0] mulB = {isMulMix ? 1'b0 : operand_r[31], operand_r};
	wire signed [65:0] prodFull = mulA * mulB;
	wire [37:0] prodLow = prodFull[37:0];
	logic [31:0] shifted;
	always_comb begin
		unique case (shiftSel_r)
			SHF_LEFT4: shifted = {prodLow[27:0], 4'h0};
			SHF_LEFT1: shifted = {prodLow[30:0], 1'b0};
			SHF_NONE: shifted = prodLow[31:0];
			SHF_RIGHT1: shifted = prodLow[32:1];
			SHF_RIGHT2: shifted = prodLow[33:2];
			SHF_RIGHT3: shifted = prodLow[34:3];
			SHF_RIGHT4: shifted = prodLow[35:4];
			SHF_RIGHT5: shifted = prodLow[36:5];
			SHF_RIGHT6: shifted = prodLow[37:6];
			default: shifted = prodLow[31:0];
		endcase
	end

	// accumulator minus old stored product, both unsigned
	wire [32:0] subWide = {1'b0, accum_r} - {1'b0, product_r};
	wire [31:0] subRes = subWide[31:0];
	wire borrow = subWide[32];
	wire subOvf = (accum_r[31] != product_r[31]) && (subRes[31] != accum_r[31]);

	// port input capture, only once the last two sync stages agree
	wire ioCapture = (ioState_r == IO_SAMPLE) && (sync2_r == sync3_r);
	wire toLow = ioCapture && (inDest == DEST_ACCUM_LOW);
	wire toHigh = ioCapture && (inDest == DEST_ACCUM_HIGH);
	wire moreReps = repeat_r != RST_HALF;

	always_comb begin
		accum_nxt = accum_r;
		product_nxt = product_r;
		flagZ_nxt = flagZ_r;
		flagN_nxt = flagN_r;
		flagC_nxt = flagC_r;
		flagV_nxt = flagV_r;
		ovfCount_nxt = ovfCount_r;
		repeat_nxt = repeat_r;
		if (wrAccum)
			accum_nxt = hwdata;
		if (wrProduct)
			product_nxt = hwdata;
		if (wrFlags) begin
			flagZ_nxt = hwdata[FLAG_Z_BIT];
			flagN_nxt = hwdata[FLAG_N_BIT];
			flagC_nxt = hwdata[FLAG_C_BIT];
			flagV_nxt = hwdata[FLAG_V_BIT];
		end
		if (wrOvfCount)
			ovfCount_nxt = hwdata[15:0];
		if (wrRepeat)
			repeat_nxt = hwdata[15:0];
		// hardware updates come last so a set beats a software clear
		if (execMul) begin
			product_nxt = shifted;
			repeat_nxt = RST_HALF;
		end
		if (execSub) begin
			accum_nxt = subRes;
			flagZ_nxt = (subRes == RST_WORD);
			flagN_nxt = subRes[31];
			flagC_nxt = !borrow;
			flagV_nxt = flagV_r || subOvf;
			if (borrow)
				ovfCount_nxt = ovfCount_r - 16'h0001;
		end
		if (toLow)
			accum_nxt = {accum_r[31:16], sync3_r};
		if (toHigh)
			accum_nxt = {sync3_r, accum_r[15:0]};
		if (toLow || toHigh) begin
			flagN_nxt = sync3_r[15];
			flagZ_nxt = (sync3_r == RST_HALF);
		end
		if (ioCapture && moreReps) begin
			repeat_nxt = repeat_r - 16'h0001;
		end
	end

	// bus slave with one wait state so read data comes from a flop
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			dataPhase_r <= 1'b0;
			write_r <= 1'b0;
			addrOk_r <= 1'b0;
			addr_r <= 8'h00;
			readyOut_r <= 1'b1;
			rdData_r <= RST_WORD;
		end else if (addrPhase) begin
			dataPhase_r <= 1'b1;
			write_r <= hwrite;
			addrOk_r <= (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'b00);
			addr_r <= haddr[7:0];
			readyOut_r <= 1'b0;
		end else if (dataPhase_r) begin
			dataPhase_r <= 1'b0;
			readyOut_r <= 1'b1;
			rdData_r <= write_r ? rdData_r : rdMux;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			shiftSel_r <= RST_SHIFT;
			object_mode_bit_r <= 1'b0;
			multiplicand_r <= RST_WORD;
			operand_r <= RST_WORD;
			cmd_r <= RST_WORD;
			start_r <= 1'b0;
			illegal_r <= 1'b0;
		end else begin
			if (wrCtrl) begin
				shiftSel_r <= hwdata[3:0];
				object_mode_bit_r <= hwdata[CTRL_MODE_BIT];
			end
			if (wrMultiplicand)
				multiplicand_r <= hwdata;
			if (wrOperand)
				operand_r <= hwdata;
			if (wrCommand)
				cmd_r <= hwdata;
			start_r <= wrCommand;
			if (start_r) begin
				illegal_r <= !legalOp;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			accum_r <= RST_WORD;
			product_r <= RST_WORD;
			flagZ_r <= 1'b0;
			flagN_r <= 1'b0;
			flagC_r <= 1'b0;
			flagV_r <= 1'b0;
			ovfCount_r <= RST_HALF;
			repeat_r <= RST_HALF;
		end else begin
			accum_r <= accum_nxt;
			product_r <= product_nxt;
			flagZ_r <= flagZ_nxt;
			flagN_r <= flagN_nxt;
			flagC_r <= flagC_nxt;
			flagV_r <= flagV_nxt;
			ovfCount_r <= ovfCount_nxt;
			repeat_r <= repeat_nxt;
		end
	end

	// input pin synchroniser
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_r <= RST_HALF;
			sync2_r <= RST_HALF;
			sync3_r <= RST_HALF;
		end else begin
			sync1_r <= extData;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	// port input engine
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ioState_r <= IO_IDLE;
			strobeCnt_r <= 3'h0;
			ioPort_r <= RST_HALF;
			ioData_r <= RST_HALF;
			extAddr_r <= '0;
			strobe_n_r <= 1'b1;
			read_n_r <= 1'b1;
		end else begin
			unique case (ioState_r)
				IO_IDLE: begin
					if (ioGo) begin
						ioPort_r <= word2;
						extAddr_r <= {{(EXT_ADDR_W-16){1'b0}}, word2};
						strobeCnt_r <= IO_STROBE_LAST;
						strobe_n_r <= 1'b0;
						read_n_r <= 1'b0;
						ioState_r <= IO_STROBE;
					end
				end
				IO_STROBE: begin
					if (strobeCnt_r == 3'h0) begin
						ioState_r <= IO_SAMPLE;
					end else begin
						strobeCnt_r <= strobeCnt_r - 3'h1;
					end
				end
				IO_SAMPLE: begin
					if (ioCapture) begin
						ioData_r <= sync3_r;
						strobe_n_r <= 1'b1;
						read_n_r <= 1'b1;
						ioState_r <= moreReps ? IO_GAP : IO_IDLE;
						if (moreReps) begin
							ioPort_r <= ioPort_r + 16'h0001;
						end
					end
				end
				IO_GAP: begin
					extAddr_r <= {{(EXT_ADDR_W-16){1'b0}}, ioPort_r};
					strobeCnt_r <= IO_STROBE_LAST;
					strobe_n_r <= 1'b0;
					read_n_r <= 1'b0;
					ioState_r <= IO_STROBE;
				end
				default: ioState_r <= IO_IDLE;
			endcase
		end
	end

	assign hreadyout = readyOut_r;
	assign hrdata = rdData_r;
	assign hresp = 1'b0 & readyOut_r;
	assign extAddr = extAddr_r;
	assign ioStrobe_n = strobe_n_r;
	assign extRead_n = read_n_r;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	property p_sub_accum;
		execSub |=> accum_r == $past(accum_r) - $past(product_r);
	endproperty
	a_sub_accum: assert property (p_sub_accum) else $error("accumulator not less old product");

	property p_left4;
		execMul && shiftSel_r == SHF_LEFT4 |=>
			product_r[3:0] == 4'h0 && product_r[31:4] == $past(prodLow[27:0]);
	endproperty
	a_left4: assert property (p_left4) else $error("left four slice wrong");

	property p_left1;
		execMul && shiftSel_r == SHF_LEFT1 |=>
			!product_r[0] && product_r[31:1] == $past(prodLow[30:0]);
	endproperty
	a_left1: assert property (p_left1) else $error("left one slice wrong");

	property p_noshift;
		execMul && shiftSel_r == SHF_NONE |=> product_r == $past(prodLow[31:0]);
	endproperty
	a_noshift: assert property (p_noshift) else $error("unshifted product wrong");

	property p_right6;
		execMul && shiftSel_r == SHF_RIGHT6 |=> product_r == $past(prodLow[37:6]);
	endproperty
	a_right6: assert property (p_right6) else $error("right six slice wrong");

	property p_flags;
		execSub |=> flagC_r == !$past(borrow) && flagZ_r == (accum_r == RST_WORD)
			&& flagN_r == accum_r[31];
	endproperty
	a_flags: assert property (p_flags) else $error("subtract flags wrong");

	property p_vsticky;
		execSub && flagV_r |=> flagV_r;
	endproperty
	a_vsticky: assert property (p_vsticky) else $error("overflow flag lost");

	property p_ovcount;
		execSub && borrow |=> ovfCount_r == $past(ovfCount_r) - 16'h0001;
	endproperty
	a_ovcount: assert property (p_ovcount) else $error("overflow counter not decremented");

	property p_norepeat;
		execMul |=> repeat_r == RST_HALF && ioState_r == IO_IDLE;
	endproperty
	a_norepeat: assert property (p_norepeat) else $error("multiply left repeat count");

	property p_strobe;
		ioGo |=> !ioStrobe_n ##1 !ioStrobe_n[*3];
	endproperty
	a_strobe: assert property (p_strobe) else $error("io strobe not asserted");

	property p_addr;
		!ioStrobe_n |-> extAddr[EXT_ADDR_W-1:16] == '0 && extAddr[15:0] == ioPort_r;
	endproperty
	a_addr: assert property (p_addr) else $error("io address lines wrong");

	property p_repinc;
		ioCapture && moreReps |=> ioPort_r == $past(ioPort_r) + 16'h0001 ##1 !ioStrobe_n;
	endproperty
	a_repinc: assert property (p_repinc) else $error("repeated input did not advance");

	c_mul_sub: cover property (execSub ##1 flagV_r);
	c_mul_mix: cover property (execMix && shiftSel_r == SHF_RIGHT6);
	c_in_rep: cover property (ioCapture && moreReps ##[1:20] ioCapture && !moreReps);
	c_borrow: cover property (execSub && borrow);

endmodule

// [verification/mli_io_device.sv]
// Purpose: port device on the external bus, answers input accesses
// Assumes: strobes active low, word on the low 16 data lines
// Notes: answers with the inverted port address, LAG cycles late
module mli_io_device
	import mli_pkg::*;
#(
	parameter int LAG = 0
)
(
	input wire logic sys_clk,
	input wire logic [mli_pkg::EXT_ADDR_W-1:0] extAddr,
	input wire logic ioStrobe_n,
	input wire logic extRead_n,
	output logic [15:0] extData
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] lastVal_r = 16'h0000;
	logic [7:0] lowCnt_r = 8'h00;
	wire selected = !ioStrobe_n && !extRead_n;
	always @(posedge sys_clk) begin
		lastVal_r <= extData;
		lowCnt_r <= selected ? 8'(lowCnt_r + 8'h01) : 8'h00;
	end
	// released or not yet valid: inverse of last value, changes every cycle
	assign extData = (selected && lowCnt_r >= LAG) ? ~extAddr[15:0] : ~lastVal_r;
endmodule

// [verification/tb_mul32_low_shift_and_io_input.sv]
// Purpose: self-checking bench for the multiply-low and port-input block
// Assumes: single AHB-Lite master, one wait state slave
// Notes: expected values come from a bench model of the datapath
module tb_mul32_low_shift_and_io_input
	import mli_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	wire logic hready;
	wire logic [31:0] hrdata;
	wire logic hresp;
	wire logic [EXT_ADDR_W-1:0] extAddr;
	wire logic [15:0] extData;
	wire logic ioStrobe_n;
	wire logic extRead_n;
	int num_errors = 0;
	int tests_run = 0;
	int cycles = 0;
	int accessCnt = 0;
	logic [31:0] accumM = 32'h0000_0000;
	logic [31:0] prodM = 32'h0000_0000;
	logic [3:0] flagM = 4'h0;
	logic [15:0] ovfM = 16'h0000;
	logic [15:0] expPort = 16'h0000;
	logic strobePrev = 1'b1;

	always #5 sys_clk = ~sys_clk;

	mli_exec u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .extAddr(extAddr),
		.extData(extData), .ioStrobe_n(ioStrobe_n), .extRead_n(extRead_n));
	mli_io_device #(.LAG(1)) u_io (.sys_clk(sys_clk), .extAddr(extAddr),
		.ioStrobe_n(ioStrobe_n), .extRead_n(extRead_n), .extData(extData));

	task automatic conclude;
		if (num_errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic ahb(input logic isWr, input logic [7:0] ofs, input logic [31:0] wd,
			output logic [31:0] rd);
		@(posedge sys_clk);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, ofs};
		htrans <= 2'h2;
		hwrite <= isWr;
		@(posedge sys_clk);
		while (hready !== 1'b1) @(posedge sys_clk);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge sys_clk);
		while (hready !== 1'b1) @(posedge sys_clk);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, ofs, d, x);
	endtask

	task automatic rdc(input logic [7:0] ofs, input logic [31:0] exp);
		logic [31:0] x;
		ahb(1'b0, ofs, 32'h0000_0000, x);
		chk(x, exp);
	endtask

	task automatic waitIdle;
		logic [31:0] s;
		repeat (100) begin
			ahb(1'b0, OFS_STATUS, 32'h0000_0000, s);
			if (s[STAT_BUSY_BIT] === 1'b0) break;
		end
	endtask

	function automatic logic [31:0] slice(logic [3:0] code, logic [31:0] mcand,
			logic [31:0] op, logic mixed);
		logic [63:0] full;
		logic [37:0] t;
		if (mixed)
			full = $signed(mcand) * $signed({32'h0000_0000, op});
		else
			full = $signed(mcand) * $signed(op);
		t = full[37:0];
		if (code == SHF_LEFT4)
			return {t[27:0], 4'h0};
		if (code == SHF_LEFT1)
			return {t[30:0], 1'b0};
		if (code >= SHF_RIGHT1 && code <= SHF_RIGHT6)
			return 32'(t >> (code - SHF_RIGHT1 + 4'h1));
		return t[31:0];
	endfunction

	task automatic mul(input logic [3:0] code, input logic [31:0] mcand, input logic [31:0] op,
			input logic mixed, input logic [15:0] rep);
		logic [32:0] d;
		wr(OFS_CTRL, 32'h0000_0010 | {28'h000_0000, code});
		wr(OFS_MULTIPLICAND, mcand);
		wr(OFS_OPERAND, op);
		wr(OFS_REPEAT, {16'h0000, rep});
		wr(OFS_COMMAND, {mixed ? OP_MUL_MIX : OP_MUL_SUB, OP_SECOND_HI, 8'h00});
		waitIdle();
		if (!mixed) begin
			d = {1'b0, accumM} - {1'b0, prodM};
			if ((accumM[31] != prodM[31]) && (d[31] != accumM[31]))
				flagM[FLAG_V_BIT] = 1'b1;
			flagM[FLAG_C_BIT] = ~d[32];
			if (d[32])
				ovfM = ovfM - 16'h0001;
			accumM = d[31:0];
			flagM[FLAG_Z_BIT] = (accumM == 32'h0000_0000);
			flagM[FLAG_N_BIT] = accumM[31];
		end
		prodM = slice(code, mcand, op, mixed);
		rdc(OFS_STATUS, 32'h0000_0000);
		rdc(OFS_PRODUCT, prodM);
		rdc(OFS_ACCUM, accumM);
		rdc(OFS_FLAGS, {28'h000_0000, flagM});
		rdc(OFS_OVF_COUNT, {16'h0000, ovfM});
		rdc(OFS_REPEAT, 32'h0000_0000);
	endtask

	task automatic portIn(input logic [7:0] dest, input logic [15:0] port,
			input logic [15:0] rep);
		logic [15:0] w;
		wr(OFS_CTRL, 32'h0000_0012);
		wr(OFS_REPEAT, {16'h0000, rep});
		expPort = port;
		accessCnt = 0;
		wr(OFS_COMMAND, {OP_PORT_IN, dest, port});
		waitIdle();
		w = ~(port + rep);
		chk(32'(accessCnt), 32'(rep) + 32'h0000_0001);
		rdc(OFS_IO_DATA, {16'h0000, w});
		if (dest == DEST_ACCUM_LOW)
			accumM[15:0] = w;
		if (dest == DEST_ACCUM_HIGH)
			accumM[31:16] = w;
		if (dest == DEST_ACCUM_LOW || dest == DEST_ACCUM_HIGH) begin
			flagM[FLAG_N_BIT] = w[15];
			flagM[FLAG_Z_BIT] = (w == 16'h0000);
		end
		rdc(OFS_ACCUM, accumM);
		rdc(OFS_FLAGS, {28'h000_0000, flagM});
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 30000) begin
			num_errors++;
			conclude();
		end
		strobePrev <= ioStrobe_n;
		if (strobePrev === 1'b1 && ioStrobe_n === 1'b0) begin
			chk(32'(extAddr), {16'h0000, expPort});
			chk({31'h0000_0000, extRead_n}, 32'h0000_0000);
			expPort = expPort + 16'h0001;
			accessCnt++;
		end
	end

	initial begin
		repeat (8) @(posedge sys_clk);
		arst_n <= 1'b1;
		rdc(OFS_CTRL, {28'h000_0000, RST_SHIFT});
		rdc(8'h30, 32'h0000_0000);
		for (int c = 0; c < 10; c++)
			mul(4'(c), 32'h8765_4321, 32'h0123_4567, 1'b0, 16'h0003);
		mul(SHF_RIGHT6, 32'hFFFF_FFF3, 32'hF000_0001, 1'b1, 16'h0005);
		mul(SHF_LEFT1, 32'h7FFF_FFFF, 32'h8000_0003, 1'b1, 16'h0000);
		mul(SHF_NONE, 32'h8000_0000, 32'h8000_0000, 1'b0, 16'h0000);
		wr(OFS_CTRL, {28'h000_0000, SHF_NONE});
		wr(OFS_COMMAND, {OP_MUL_SUB, OP_SECOND_HI, 8'h00});
		waitIdle();
		rdc(OFS_STATUS, 32'h0000_0002);
		rdc(OFS_PRODUCT, prodM);
		portIn(DEST_ACCUM_LOW, 16'h0300, 16'h0002);
		portIn(8'h05, 16'h1234, 16'h0001);
		portIn(DEST_ACCUM_HIGH, 16'hFFFF, 16'h0000);
		conclude();
	end
endmodule
